// ---- rtl/isoc_offset_ctrl.sv ----
// isoc_offset_ctrl: per-stream input frame offset control with register slave
// assumes tdm clock, frame pulse and stream inputs synchronous to SYS_CLK_IN
//
// Contract
// - three-bit offset sets bit-0 capture delay
// - offset reaches up to plus 4.5 periods
// - first mode: latch bit clear means rising
// - gci mode: latch bit clear means falling
// - shift is offset plus half when set
// - all clear gives no shift, the default
// - upper register packs streams four to seven
// - offset registers reset to all zeros
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module isoc_offset_ctrl
    import isoc_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [ADDR_BITS-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [DATA_BITS-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [DATA_BITS-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic TDM_CLK_IN,
    input wire logic FRAME_PULSE_INPUT_IN,
    input wire logic [NUM_STREAMS-1:0] RX_STREAM_IN,
    output logic [8*NUM_STREAMS-1:0] RX_BYTE_OUT,
    output logic [NUM_STREAMS-1:0] RX_VALID_OUT,
    output logic [NUM_STREAMS-1:0] RX_FIRST_OUT
);
    logic [15:0] offset_lower_q;
    logic [15:0] input_offset_streams_upper_q;
    logic gci_mode_q;
    logic [3:0] convert_q;
    logic wait_q;
    logic [DATA_BITS-1:0] readdata_q;
    logic tdm_clk_q;

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, answer on the second edge
    wire req_w = AVS_READ_IN || AVS_WRITE_IN;
    wire ack_w = req_w && !wait_q;
    wire wr_ack_w = AVS_WRITE_IN && !wait_q;
    wire sel_lower_w = AVS_ADDRESS_IN == REG_OFFSET_LOWER;
    wire sel_upper_w = AVS_ADDRESS_IN == REG_OFFSET_UPPER;
    wire sel_ctrl_w = AVS_ADDRESS_IN == REG_CONTROL;
    wire sel_conv_w = AVS_ADDRESS_IN == REG_CONVERT;
    wire [3:0] conv_nib_w = delay_to_nibble(convert_q);
    wire [DATA_BITS-1:0] rd_mux_w =
        sel_lower_w ? {16'h0000, offset_lower_q} :
        sel_upper_w ? {16'h0000, input_offset_streams_upper_q} :
        sel_ctrl_w ? {31'h0000_0000, gci_mode_q} :
        sel_conv_w ? {24'h00_0000, conv_nib_w, convert_q} :
        READ_UNMAPPED;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            wait_q <= 1'b1;
            readdata_q <= READ_UNMAPPED;
        end else begin
            wait_q <= !(req_w && wait_q);
            if (AVS_READ_IN && wait_q) begin
                readdata_q <= rd_mux_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            offset_lower_q <= OFFSET_RESET;
            input_offset_streams_upper_q <= OFFSET_RESET;
            gci_mode_q <= 1'b0;
            convert_q <= 4'h0;
        end else if (wr_ack_w) begin
            if (sel_lower_w) begin
                offset_lower_q <= merge16(offset_lower_q, AVS_WRITEDATA_IN[15:0],
                                          AVS_BYTEENABLE_IN[1:0]);
            end
            if (sel_upper_w) begin
                input_offset_streams_upper_q <= merge16(input_offset_streams_upper_q,
                    AVS_WRITEDATA_IN[15:0], AVS_BYTEENABLE_IN[1:0]);
            end
            if (sel_ctrl_w && AVS_BYTEENABLE_IN[0]) begin
                gci_mode_q <= AVS_WRITEDATA_IN[CTRL_GCI_MODE];
            end
            if (sel_conv_w && AVS_BYTEENABLE_IN[0]) begin
                convert_q <= AVS_WRITEDATA_IN[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tdm clock edges and frame reference
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            tdm_clk_q <= 1'b0;
        end else begin
            tdm_clk_q <= TDM_CLK_IN;
        end
    end

    wire tdm_rise_w = TDM_CLK_IN && !tdm_clk_q;
    wire tdm_fall_w = !TDM_CLK_IN && tdm_clk_q;
    wire tdm_edge_w = tdm_rise_w || tdm_fall_w;
    // reference edge polarity flips with mode so the 3/4 point edge flips too
    wire ref_edge_w = gci_mode_q ? tdm_rise_w : tdm_fall_w;
    wire frame_ref_w = ref_edge_w && FRAME_PULSE_INPUT_IN;
    wire [31:0] offsets_w = {input_offset_streams_upper_q, offset_lower_q};

    ////////////////////////////////////////////////////////////////////////
    // one receiver per stream, each fed its own nibble
    wire [3:0] shift_w [NUM_STREAMS];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STREAMS; gi++) begin : g_lane
            assign shift_w[gi] = nibble_shift(offsets_w[4*gi +: 4]);
            isoc_rx_lane u_lane (
                .clk_in(SYS_CLK_IN),
                .rst_n_in(RSTN_IN),
                .edge_in(tdm_edge_w),
                .frame_ref_in(frame_ref_w),
                .shift_in(shift_w[gi]),
                .data_in(RX_STREAM_IN[gi]),
                .byte_out(RX_BYTE_OUT[8*gi +: 8]),
                .valid_out(RX_VALID_OUT[gi]),
                .first_out(RX_FIRST_OUT[gi])
            );
        end
    endgenerate

    assign AVS_READDATA_OUT = readdata_q;
    assign AVS_WAITREQUEST_OUT = wait_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_upper_write;
        wr_ack_w && sel_upper_w && AVS_BYTEENABLE_IN[1:0] == 2'b11;
    endsequence

    a_reset_zero_regs: assert property (@(posedge SYS_CLK_IN)
        !RSTN_IN |=> offset_lower_q == OFFSET_RESET
                     && input_offset_streams_upper_q == OFFSET_RESET)
        else $error("offset registers not cleared by reset");
    a_upper_stream7_map: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        s_upper_write |=> shift_w[7] == {$past(AVS_WRITEDATA_IN[15:13]), 1'b0}
                                        + {3'h0, $past(AVS_WRITEDATA_IN[12])})
        else $error("stream 7 shift does not follow bits 15 to 12");
    a_stream_independent: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        s_upper_write |=> $stable(offset_lower_q) && shift_w[0] == $past(shift_w[0]))
        else $error("upper write disturbed a lower stream");
    a_ref_edge_mode: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        frame_ref_w |-> FRAME_PULSE_INPUT_IN && TDM_CLK_IN != tdm_clk_q
                        && TDM_CLK_IN == gci_mode_q)
        else $error("frame reference on wrong clock edge for mode");
    a_max_shift_range: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        input_offset_streams_upper_q[15:13] <= 3'h4 |-> shift_w[7] <= MAX_SHIFT_HALVES)
        else $error("legal offset exceeds 4.5 periods");
    a_bus_one_wait: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        req_w && wait_q |=> !wait_q ##1 wait_q)
        else $error("bus answer not after exactly one wait cycle");
endmodule : isoc_offset_ctrl
`default_nettype wire

// ---- rtl/isoc_rx_lane.sv ----
// isoc_rx_lane: one input stream receiver with programmable frame offset
// assumes edge and frame reference strobes are one-cycle pulses on the system clock
`timescale 1ns/1ns
`default_nettype none
module isoc_rx_lane
    import isoc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic edge_in,
    input wire logic frame_ref_in,
    input wire logic [3:0] shift_in,
    input wire logic data_in,
    output logic [7:0] byte_out,
    output logic valid_out,
    output logic first_out
);
    logic [REL_BITS-1:0] rel_q;
    logic [3:0] pend_q;
    logic armed_q;
    logic [7:0] shreg_q;
    logic [7:0] byte_q;
    logic valid_q;
    logic first_q;

    ////////////////////////////////////////////////////////////////////////
    // half-period position relative to the shifted frame start
    wire restart_w = frame_ref_in ? (shift_in == 4'h0)
                                  : (armed_q && pend_q == 4'h1);
    wire [REL_BITS-1:0] new_rel_w = restart_w ? '0 : rel_q + 10'h001;
    wire sample_w = edge_in && new_rel_w[1:0] == LATCH_PHASE;
    wire [7:0] sh_d = {shreg_q[6:0], data_in};
    wire done_w = sample_w && new_rel_w[4:2] == LAST_BIT;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rel_q <= '0;
            pend_q <= 4'h0;
            armed_q <= 1'b0;
            shreg_q <= 8'h00;
        end else if (edge_in) begin
            rel_q <= new_rel_w;
            if (frame_ref_in) begin
                pend_q <= shift_in;
                armed_q <= shift_in != 4'h0;
            end else if (armed_q) begin
                pend_q <= pend_q - 4'h1;
                armed_q <= pend_q != 4'h1;
            end
            if (sample_w) begin
                shreg_q <= sh_d;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            byte_q <= 8'h00;
            valid_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            valid_q <= done_w;
            if (done_w) begin
                byte_q <= sh_d;
                first_q <= new_rel_w[REL_BITS-1:5] == 5'h00;
            end
        end
    end

    assign byte_out = byte_q;
    assign valid_out = valid_q;
    assign first_out = first_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_ref_with_shift;
        edge_in && frame_ref_in && shift_in != 4'h0;
    endsequence
    sequence s_armed_loaded(logic [3:0] s);
        armed_q && pend_q == s;
    endsequence

    a_shift_arms_wait: assert property (
        s_ref_with_shift |=> s_armed_loaded($past(shift_in)))
        else $error("nonzero shift did not arm the delay");
    a_zero_shift_start: assert property (
        edge_in && frame_ref_in && shift_in == 4'h0 |=> rel_q == '0 && !armed_q)
        else $error("zero shift did not restart at the reference edge");
    a_delayed_start: assert property (
        edge_in && !frame_ref_in && armed_q && pend_q == 4'h1 |=> rel_q == '0 && !armed_q)
        else $error("delayed frame start missed");
    a_byte_at_phase: assert property (
        valid_q |-> $past(edge_in) && $past(new_rel_w[4:0]) == 5'h1f)
        else $error("byte completed off the latch phase");
endmodule : isoc_rx_lane
`default_nettype wire

// ---- shared/isoc_pkg.sv ----
// isoc_pkg: constants for the input stream offset control block
// assumes a 100 MHz system clock and an Avalon-MM byte-addressed register slave
package isoc_pkg;
    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned NUM_STREAMS = 8;
    localparam int unsigned NIBBLE_BITS = 4;
    localparam int unsigned ADDR_BITS = 4;
    localparam int unsigned DATA_BITS = 32;
    localparam int unsigned REL_BITS = 10;

    // register byte addresses
    localparam logic [3:0] REG_OFFSET_LOWER = 4'h0;
    localparam logic [3:0] REG_OFFSET_UPPER = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam logic [3:0] REG_CONVERT = 4'hC;

    // reset values
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // field positions inside a stream nibble and the control and convert registers
    localparam int unsigned NIB_OFFSET_LSB = 1;
    localparam int unsigned NIB_LATCH_EDGE = 0;
    localparam int unsigned CTRL_GCI_MODE = 0;
    localparam int unsigned CONV_HALF_FLAG = 3;

    // bit cell timing in half clock periods
    localparam logic [1:0] LATCH_PHASE = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] MAX_SHIFT_HALVES = 4'h9;

    // whole-period offset plus latch edge, in half clock periods
    function automatic logic [3:0] nibble_shift(input logic [3:0] nib);
        nibble_shift = {nib[3:1], 1'b0} + {3'h0, nib[NIB_LATCH_EDGE]};
    endfunction : nibble_shift

    // measured delay {half flag, periods} to offset nibble
    function automatic logic [3:0] delay_to_nibble(input logic [3:0] meas);
        delay_to_nibble = {meas[2:0], ~meas[CONV_HALF_FLAG]};
    endfunction : delay_to_nibble

    // byte-lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16
endpackage : isoc_pkg

// ---- test/isoc_tdm_src.sv ----
// isoc_tdm_src: backplane model with bit clock, frame pulse and eight data lines
// assumes a free-running system clock; a bit clock half period is six system cycles
`timescale 1ns/1ns
`default_nettype none
module isoc_tdm_src (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic gci_in,
    output logic tdm_clk_out,
    output logic frame_pulse_out,
    output logic [7:0] stream_out,
    output logic mark_out
);
    localparam logic [63:0] PAT = 64'h1d3c_a597_6e28_f0b5;
    logic [2:0] cyc_q;
    logic [9:0] edge_q;
    wire logic [9:0] next_edge = edge_q + 10'h001;
    // edge 0 is falling in first mode and rising in gci mode
    assign tdm_clk_out = edge_q[0] ^ gci_in;
    assign mark_out = (edge_q == 10'h000) && (cyc_q == 3'h0);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cyc_q <= 3'h0;
            edge_q <= 10'h000;
            frame_pulse_out <= 1'b0;
            stream_out <= 8'h00;
        end else begin
            cyc_q <= (cyc_q == 3'h5) ? 3'h0 : cyc_q + 3'h1;
            if (cyc_q == 3'h5) edge_q <= next_edge;
            if (cyc_q == 3'h2) begin
                // data and frame pulse change mid half period, stable at each edge
                stream_out <= {8{PAT[next_edge[5:0]]}};
                frame_pulse_out <= (next_edge == 10'h000);
            end
        end
    end
endmodule : isoc_tdm_src
`default_nettype wire

// ---- test/tb.sv ----
// tb: register and serial checks for the offset control block
// assumes isoc_tdm_src as backplane and a one-wait-cycle register slave
`timescale 1ns/1ns
`default_nettype none
module tb;
    import isoc_pkg::*;
    localparam int LIMIT = 60000;
    localparam logic [63:0] PAT = 64'h1d3c_a597_6e28_f0b5;
    logic sys_clk, rst_n, rd, wr, gci, tdm_clk, fpulse, mark, waitreq;
    logic [3:0] addr, be, nib;
    logic [31:0] wdata, rdata, rword;
    logic [63:0] rx_byte;
    logic [7:0] rx_valid, rx_first, streams;
    int err_count, total_checks, cycles;
    ////////////////////////////////////////
    isoc_offset_ctrl dut (
        .SYS_CLK_IN(sys_clk), .RSTN_IN(rst_n), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
        .TDM_CLK_IN(tdm_clk), .FRAME_PULSE_INPUT_IN(fpulse), .RX_STREAM_IN(streams),
        .RX_BYTE_OUT(rx_byte), .RX_VALID_OUT(rx_valid), .RX_FIRST_OUT(rx_first)
    );
    isoc_tdm_src src (
        .clk_in(sys_clk), .rst_n_in(rst_n), .gci_in(gci), .tdm_clk_out(tdm_clk),
        .frame_pulse_out(fpulse), .stream_out(streams), .mark_out(mark)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] e);
        @(posedge sys_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= e;
        forever begin
            @(posedge sys_clk);
            if (waitreq === 1'b0) break;
        end
        rword = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    function automatic logic [7:0] exp_byte(input logic [3:0] s);
        for (int k = 0; k < 8; k++) exp_byte[7-k] = PAT[s + 4*k + 3];
    endfunction : exp_byte
    task automatic frame_check(input logic [31:0] nibs);
        logic [7:0] seen;
        seen = 8'h00;
        repeat (2) begin
            @(posedge sys_clk);
            while (mark !== 1'b1) @(posedge sys_clk);
        end
        repeat (6200) begin
            @(posedge sys_clk);
            for (int n = 0; n < 8; n++) begin
                if ({rx_valid[n], rx_first[n], seen[n]} === 3'b110) begin
                    check("first byte", {24'h00_0000, exp_byte(nibs[4*n +: 4])},
                          {24'h00_0000, rx_byte[8*n +: 8]});
                    seen[n] = 1'b1;
                end
            end
        end
        check("streams seen", 32'h0000_00ff, {24'h00_0000, seen});
    endtask : frame_check
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {rst_n, rd, wr, gci, addr, be, wdata} <= '0;
        repeat (16) @(posedge sys_clk);
        check("wait in reset", 32'h0000_0001, {31'h0000_0000, waitreq});
        rst_n <= 1'b1;
        bus(1'b0, REG_OFFSET_LOWER, 32'h0000_0000, 4'hf);
        check("lower reset", {16'h0000, OFFSET_RESET}, rword);
        bus(1'b0, REG_OFFSET_UPPER, 32'h0000_0000, 4'hf);
        check("upper reset", {16'h0000, OFFSET_RESET}, rword);
        bus(1'b1, REG_OFFSET_UPPER, 32'hffff_9a5c, 4'hf);
        bus(1'b0, REG_OFFSET_UPPER, 32'h0000_0000, 4'hf);
        check("upper all", 32'h0000_9a5c, rword);
        bus(1'b1, REG_OFFSET_UPPER, 32'h0000_3700, 4'h2);
        bus(1'b1, 4'h6, 32'h0000_1234, 4'hf);
        bus(1'b0, 4'h6, 32'h0000_0000, 4'hf);
        check("unmapped", READ_UNMAPPED, rword);
        bus(1'b0, REG_OFFSET_UPPER, 32'h0000_0000, 4'hf);
        check("upper lane", 32'h0000_375c, rword);
        bus(1'b1, REG_OFFSET_UPPER, 32'h0000_e0a1, 4'h1);
        bus(1'b0, REG_OFFSET_UPPER, 32'h0000_0000, 4'hf);
        check("lower lane", 32'h0000_37a1, rword);
        for (int i = 0; i < 10; i++) begin
            nib = 4'(i);
            bus(1'b1, REG_CONVERT, {28'h000_0000, ~nib[0], nib[3:1]}, 4'hf);
            bus(1'b0, REG_CONVERT, 32'h0000_0000, 4'hf);
            check("convert", {24'h00_0000, nib, ~nib[0], nib[3:1]}, rword);
        end
        bus(1'b1, REG_OFFSET_LOWER, 32'h0000_3210, 4'h3);
        bus(1'b1, REG_OFFSET_UPPER, 32'h0000_9876, 4'h3);
        frame_check(32'h9876_3210);
        gci <= 1'b1;
        bus(1'b1, REG_CONTROL, 32'h0000_0001, 4'hf);
        bus(1'b0, REG_CONTROL, 32'h0000_0000, 4'hf);
        check("gci mode", 32'h0000_0001, rword);
        bus(1'b1, REG_OFFSET_LOWER, 32'h0000_6789, 4'h3);
        bus(1'b1, REG_OFFSET_UPPER, 32'h0000_0123, 4'h3);
        frame_check(32'h0123_6789);
        conclude();
    end
endmodule : tb
`default_nettype wire
